// ===== adcr_map.vh
/*
 * adcr_map.vh: register offsets, field positions, reset values and
 * timing counts of the converter control and readout block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADCR_MAP_VH
`define ADCR_MAP_VH

// register byte addresses, one aligned word each
`define ADCR_OFS_CONFIG     8'h00
`define ADCR_OFS_STATUS     8'h04
`define ADCR_OFS_DATA       8'h08
`define ADCR_OFS_COMMAND    8'h0c

// main_config_register fields
`define ADCR_CFG_CLKOUTEN   0
`define ADCR_CFG_MONSEL_LO  1
`define ADCR_CFG_MONSEL_HI  2
`define ADCR_CFG_RESET      3'h1

// monitor select codes
`define ADCR_MON_INPUT      2'h0
`define ADCR_MON_SUPPLY     2'h1
`define ADCR_MON_GAIN       2'h2
`define ADCR_MON_REF        2'h3

// status fields
`define ADCR_ST_NEW         0
`define ADCR_ST_SUPPLY      1
`define ADCR_ST_CONV        2
`define ADCR_ST_POWER_DOWN_N        3
`define ADCR_ST_CLOCK_SOURCE_SELECT      4

// command fields
`define ADCR_CMD_RESET      0

// least low time of reset and power-down pins, system clock cycles
`define ADCR_MIN_HOLD       3'h2

// conversion length in system clock cycles
`define ADCR_CONV_CYCLES    16'h0040

// code scaling: positive reference gives this code
`define ADCR_REF_CODE       16'h7800
`define ADCR_ACC_FS_SHIFT   22
`define ADCR_CODE_MAX       16'h7fff
`define ADCR_CODE_MIN       16'h8000

`endif

// ===== adcr_sync.v
/*
 * adcr_sync: two flip-flop synchroniser for a bundle of levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ps
module adcr_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input  wire             ref_clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_r;
	reg [WIDTH-1:0] stage2_r;

	always @(posedge ref_clk) begin
		if (rst) begin
			stage1_r <= INIT;
			stage2_r <= INIT;
		end else begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;
endmodule

// ===== adcr_hold_det.v
/*
 * adcr_hold_det: reports a synchronised active-low level once it has
 * stayed low for at least MIN_HOLD clock cycles.
 * Assumes the input already passed a synchroniser.
 */
`timescale 1ns/1ps
`include "adcr_map.vh"
module adcr_hold_det #(
	parameter [2:0] MIN_HOLD = `ADCR_MIN_HOLD
) (
	input  wire ref_clk,
	input  wire rst,
	input  wire levelN,
	output wire held
);
	reg [2:0] count_r;

	// short glitches below the hold time are ignored
	always @(posedge ref_clk) begin
		if (rst)
			count_r <= 3'h0;
		else if (levelN)
			count_r <= 3'h0;
		else if (count_r != MIN_HOLD)
			count_r <= count_r + 3'h1;
	end

	assign held = (count_r == MIN_HOLD);
endmodule

// ===== adcr_ctrl.v
/*
 * adcr_ctrl: conversion control and readout of a multiplexed converter:
 * master reset sources, clock source selection, clock output, start/stop,
 * data-ready handshake, code scaling with clipping, monitor channels,
 * supply-low flag and an AHB-Lite register slave.
 * Assumes the analog side supplies a signed accumulator value and monitor
 * codes, and comparator levels for the supply; the serial port decodes
 * commands elsewhere and only its clock and select reach this block.
 */
// Contract
// RULE1: reset pin held low two clocks restores defaults, clears filter, then ready.
// RULE2: analog supply crossing reset threshold triggers the same master reset.
// RULE3: clock select low picks crystal, high picks external clock pin.
// RULE4: crystal clock driven out only while clock output enable set; default set.
// RULE5: start high begins converting selected channels.
// RULE6: start low lets current conversion finish, then idle.
// RULE7: data ready goes low on new data; unread result is overwritten.
// RULE8: first serial clock falling edge in a read returns data ready high.
// RULE9: unread data ready stays low, pulses high then low on fresh result.
// RULE10: status new-data flag is one while fresh data present.
// RULE11: positive reference input gives code 7800h.
// RULE12: sixteen-bit two's complement codes saturate at 7FFFh and 8000h.
// RULE13: supply monitor returns supply difference, code over 3072 gives volts.
// RULE14: host clears chop averaging before monitor readings.
// RULE15: supply below trip forces supply data zero and sets supply-low flag.
// RULE16: supply-low flag clears only after supply rises past hysteresis.
// RULE17: gain monitor code 30720 means unity gain.
// RULE18: reference monitor code over C00h gives reference volts.
// RULE19: power-down low two clocks enters power-down, registers kept.
// RULE20: start and reset inputs synchronised before use.
`timescale 1ns/1ps
`include "adcr_map.vh"
module adcr_ctrl #(
	parameter [15:0] CONV_CYCLES = `ADCR_CONV_CYCLES,
	parameter        ACC_WIDTH   = 24
) (
	input  wire                        ref_clk,
	input  wire                        rst,
	// AHB-Lite slave
	input  wire                        hsel,
	input  wire [7:0]                  haddr,
	input  wire [1:0]                  htrans,
	input  wire                        hwrite,
	input  wire [2:0]                  hsize,
	input  wire [31:0]                 hwdata,
	input  wire                        hready,
	output wire                        hreadyout,
	output wire                        hresp,
	output reg  [31:0]                 hrdata,
	// device pins
	input  wire                        resetPinN,
	input  wire                        powerDownN,
	input  wire                        startPin,
	input  wire                        clockSourceSelect,
	input  wire                        xtalClk,
	input  wire                        bidirClockPinIn,
	output wire                        bidirClockPinOut,
	output wire                        bidirClockPinOe,
	output wire                        sysClkOut,
	output reg                         dataReadyN,
	input  wire                        sclk,
	input  wire                        csN,
	// analog side
	input  wire                        avddAboveReset,
	input  wire                        supplyBelowTrip,
	input  wire                        supplyAboveHyst,
	input  wire signed [ACC_WIDTH-1:0] accumIn,
	input  wire [15:0]                 supplyCode,
	input  wire [15:0]                 gainCode,
	input  wire [15:0]                 refCode,
	output wire                        filterClear,
	output wire                        converting
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_CONV = 2'b10;

	// scale to 7800h per reference, then clip to sixteen bits
	function [15:0] scaleClip;
		input signed [ACC_WIDTH-1:0] acc;
		reg signed [ACC_WIDTH+16:0] prod;
		reg signed [ACC_WIDTH+16:0] shifted;
		begin
			prod    = acc * $signed({1'b0, `ADCR_REF_CODE}); // RULE11
			shifted = prod >>> `ADCR_ACC_FS_SHIFT;
			if (shifted > $signed({{(ACC_WIDTH+1){1'b0}}, `ADCR_CODE_MAX}))
				scaleClip = `ADCR_CODE_MAX; // RULE12
			else if (shifted < $signed({{(ACC_WIDTH+1){1'b1}}, `ADCR_CODE_MIN}))
				scaleClip = `ADCR_CODE_MIN; // RULE12
			else
				scaleClip = shifted[15:0]; // RULE12
		end
	endfunction

	// pin synchronisers; reset values match idle levels so releasing
	// reset makes no false supply edge and no false supply-low event
	wire [8:0] pinsS;

	adcr_sync #(
		.WIDTH (9),
		.INIT  (9'h163)
	) uPinSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn ({supplyAboveHyst, supplyBelowTrip, avddAboveReset, csN, sclk,
			clockSourceSelect, startPin, powerDownN, resetPinN}),
		.syncOut (pinsS)
	); // RULE20

	wire resetPinNS   = pinsS[0];
	wire powerDownNS  = pinsS[1];
	wire startS       = pinsS[2];
	wire clkSelS      = pinsS[3];
	wire sclkS        = pinsS[4];
	wire csNS         = pinsS[5];
	wire avddOkS      = pinsS[6];
	wire belowTripS   = pinsS[7];
	wire aboveHystS   = pinsS[8];

	// a pin low for less than the hold time is taken as a glitch
	wire resetHeld;
	wire powerDownHeld;

	adcr_hold_det uResetHold (
		.ref_clk (ref_clk),
		.rst     (rst),
		.levelN  (resetPinNS),
		.held    (resetHeld)
	); // RULE1

	adcr_hold_det uPwdnHold (
		.ref_clk (ref_clk),
		.rst     (rst),
		.levelN  (powerDownNS),
		.held    (powerDownHeld)
	); // RULE19

	// edge detection on synchronised levels
	reg  avddOkD_r;
	reg  sclkD_r;
	wire porRise  = avddOkS & ~avddOkD_r;
	wire sclkFall = sclkD_r & ~sclkS;

	always @(posedge ref_clk) begin
		if (rst) begin
			avddOkD_r <= 1'b1;
			sclkD_r   <= 1'b0;
		end else begin
			avddOkD_r <= avddOkS;
			sclkD_r   <= sclkS;
		end
	end

	// AHB-Lite address phase capture; hsize is ignored since every
	// register is one whole word, and reads never stall the bus
	reg        wrPend_r;
	reg  [7:0] wrAddr_r;
	wire       accept = hsel & htrans[1] & hready;
	wire       rdAcc  = accept & ~hwrite;
	wire       wrData = wrPend_r;
	wire       cmdReset = wrData & (wrAddr_r == `ADCR_OFS_COMMAND) & hwdata[`ADCR_CMD_RESET];

	// one master reset for pin, supply and command sources
	wire masterReset = rst | resetHeld | porRise | cmdReset; // RULE1 RULE2

	assign filterClear = masterReset; // RULE1
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;

	always @(posedge ref_clk) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= accept & hwrite;
			wrAddr_r <= haddr;
		end
	end

	// main_config_register
	reg  [2:0] cfg_r;
	reg  [2:0] cfg_nxt;
	wire       cfgWr = wrData & (wrAddr_r == `ADCR_OFS_CONFIG);

	always @* begin
		cfg_nxt = cfg_r;
		if (cfgWr)
			cfg_nxt = hwdata[2:0];
	end

	// registers keep their contents in power-down
	always @(posedge ref_clk) begin
		if (masterReset)
			cfg_r <= `ADCR_CFG_RESET; // RULE4 RULE1
		else
			cfg_r <= cfg_nxt; // RULE19
	end

	wire       clkOutEn = cfg_r[`ADCR_CFG_CLKOUTEN];
	wire [1:0] monSel   = cfg_r[`ADCR_CFG_MONSEL_HI:`ADCR_CFG_MONSEL_LO];

	// power-down state
	reg powerDown_r;

	always @(posedge ref_clk) begin
		if (rst)
			powerDown_r <= 1'b0;
		else
			powerDown_r <= powerDownHeld; // RULE19
	end

	// clock source and clock output; the select is a strap, so a
	// mux glitch on change is accepted rather than a glitch-free switch
	assign sysClkOut        = clkSelS ? bidirClockPinIn : xtalClk; // RULE3
	assign bidirClockPinOut = xtalClk; // RULE4
	assign bidirClockPinOe  = ~clkSelS & clkOutEn & ~powerDown_r; // RULE4

	// supply-low flag with hysteresis from the comparators
	reg supplyLow_r;

	always @(posedge ref_clk) begin
		if (masterReset)
			supplyLow_r <= 1'b0;
		else if (belowTripS)
			supplyLow_r <= 1'b1; // RULE15
		else if (aboveHystS)
			supplyLow_r <= 1'b0; // RULE16
	end

	// conversion sequencer
	reg [1:0]  state_r;
	reg [15:0] convCnt_r;
	wire       convDone = (state_r == ST_CONV) && (convCnt_r == CONV_CYCLES - 16'h0001);

	always @(posedge ref_clk) begin
		if (masterReset || powerDown_r) begin
			state_r   <= ST_IDLE;
			convCnt_r <= 16'h0000;
		end else begin
			case (state_r)
			ST_IDLE: begin
				convCnt_r <= 16'h0000;
				if (startS)
					state_r <= ST_CONV; // RULE5
			end
			ST_CONV: begin
				if (convDone) begin
					convCnt_r <= 16'h0000;
					// start sampled only at the boundary, so dropping
					// start never cuts a running conversion short
					if (!startS)
						state_r <= ST_IDLE; // RULE6
				end else begin
					convCnt_r <= convCnt_r + 16'h0001;
				end
			end
			default: begin
				state_r   <= ST_IDLE;
				convCnt_r <= 16'h0000;
			end
			endcase
		end
	end

	assign converting = (state_r == ST_CONV);

	// result selection for the chosen channel
	reg [15:0] resultSel;

	always @* begin
		case (monSel)
		`ADCR_MON_SUPPLY:
			resultSel = supplyLow_r ? 16'h0000 : supplyCode; // RULE13 RULE15
		`ADCR_MON_GAIN:
			resultSel = gainCode; // RULE17
		`ADCR_MON_REF:
			resultSel = refCode; // RULE18
		default:
			resultSel = scaleClip(accumIn); // RULE11 RULE12
		endcase
	end

	// result register, new-data flag and data-ready
	// a serial read clears the flag too, so polling and the pin agree;
	// the high pulse lasts one clock and results come CONV_CYCLES apart
	reg [15:0] result_r;
	reg        newData_r;
	reg        drdyRelow_r;
	wire       readRun  = ~csNS;
	wire       dataRdAcc = rdAcc & (haddr == `ADCR_OFS_DATA);
	wire       statRdAcc = rdAcc & (haddr == `ADCR_OFS_STATUS);

	always @(posedge ref_clk) begin
		if (masterReset) begin
			result_r    <= 16'h0000; // RULE1
			newData_r   <= 1'b0;
			dataReadyN  <= 1'b1;
			drdyRelow_r <= 1'b0;
		end else begin
			if (convDone)
				result_r <= resultSel; // RULE7
			// set wins over the read clear
			if (convDone)
				newData_r <= 1'b1; // RULE10
			else if (dataRdAcc || statRdAcc || (readRun && sclkFall))
				newData_r <= 1'b0;
			drdyRelow_r <= 1'b0;
			if (convDone) begin
				if (!dataReadyN) begin
					dataReadyN  <= 1'b1; // RULE9
					drdyRelow_r <= 1'b1;
				end else begin
					dataReadyN <= 1'b0; // RULE7
				end
			end else if (drdyRelow_r) begin
				dataReadyN <= 1'b0; // RULE9
			end else if (readRun && sclkFall) begin
				dataReadyN <= 1'b1; // RULE8
			end
		end
	end

	// read data, captured at the address phase for zero wait states;
	// config reads see a write still in its data phase
	always @(posedge ref_clk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (rdAcc) begin
			case (haddr)
			`ADCR_OFS_CONFIG:
				hrdata <= {29'h00000000, cfg_nxt};
			`ADCR_OFS_STATUS:
				hrdata <= {27'h0000000, clkSelS, powerDown_r, converting,
					supplyLow_r, newData_r}; // RULE10 RULE15
			`ADCR_OFS_DATA:
				hrdata <= {16'h0000, result_r};
			default:
				hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ===== adcr_asserts.sv
/*
 * adcr_asserts: port-level checks of the converter control block.
 * Assumes binding into adcr_ctrl and a bench value of 8 for CONV_CYCLES.
 */
`timescale 1ns/1ps
module adcr_asserts #(
	parameter [15:0] CONV_CYCLES = 16'h0008
) (
	input wire ref_clk,
	input wire rst,
	input wire resetPinN,
	input wire powerDownN,
	input wire startPin,
	input wire clockSourceSelect,
	input wire xtalClk,
	input wire bidirClockPinIn,
	input wire bidirClockPinOut,
	input wire bidirClockPinOe,
	input wire sysClkOut,
	input wire dataReadyN,
	input wire filterClear,
	input wire converting
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// three samples cover the two-stage select synchroniser
	ext_sel_a: assert property (clockSourceSelect [*3] |-> !bidirClockPinOe)
		else $error("clock pin driven with external clock selected");
	clk_drive_a: assert property (bidirClockPinOe |-> bidirClockPinOut == sysClkOut && sysClkOut == xtalClk)
		else $error("clock pin does not carry crystal clock");
	clk_mux_a: assert property (clockSourceSelect [*3] |-> sysClkOut == bidirClockPinIn)
		else $error("system clock not taken from clock pin");
	data_ready_n_fall_a: assert property ($fell(dataReadyN) |-> $past(converting, 2))
		else $error("data ready fell without a conversion");
	conv_len_a: assert property ($rose(converting) |-> converting [*8])
		else $error("conversion cut short");
	conv_start_a: assert property ($rose(converting) |-> $past(startPin, 2) || $past(startPin, 3))
		else $error("conversion began without start");
	pd_stop_a: assert property (!powerDownN [*6] |-> !converting && !bidirClockPinOe)
		else $error("activity during power-down");
	rst_pin_a: assert property (!resetPinN [*6] |-> filterClear)
		else $error("reset pin held low without master reset");
endmodule

bind adcr_ctrl adcr_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
	.ref_clk(ref_clk), .rst(rst), .resetPinN(resetPinN), .powerDownN(powerDownN),
	.startPin(startPin), .clockSourceSelect(clockSourceSelect), .xtalClk(xtalClk),
	.bidirClockPinIn(bidirClockPinIn), .bidirClockPinOut(bidirClockPinOut),
	.bidirClockPinOe(bidirClockPinOe), .sysClkOut(sysClkOut), .dataReadyN(dataReadyN),
	.filterClear(filterClear), .converting(converting));

// ===== adcr_host.sv
/*
 * adcr_host: serial host that clocks one read byte out of the device.
 * Assumes go rises once per read; the serial clock idles low between frames.
 */
`timescale 1ns/1ps
module adcr_host (
	input  wire  go,
	output logic sclk,
	output logic csN,
	output logic done
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		done = 1'b0;
		forever begin
			@(posedge go);
			done = 1'b0;
			#130 csN = 1'b0;
			repeat (8) begin
				#400 sclk = 1'b1;
				#400 sclk = 1'b0;
			end
			#400 csN = 1'b1;
			done = 1'b1;
		end
	end
endmodule

// ===== adc_conversion_control_readout_test.sv
/*
 * Bench for adcr_ctrl: register tasks over AHB-Lite and pin scenarios.
 * Assumes adcr_host as serial partner and CONV_CYCLES of 8.
 */
`timescale 1ns/1ps
module adc_conversion_control_readout_test;
	logic               ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic               resetPinN, powerDownN, startPin, clockSourceSelect, xtalClk;
	logic               bidirClockPinIn, bidirClockPinOut, bidirClockPinOe, sysClkOut;
	logic               dataReadyN, sclk, csN, avddAboveReset, supplyBelowTrip;
	logic               supplyAboveHyst, filterClear, converting, go, done;
	logic [7:0]         haddr;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic [31:0]        hwdata, hrdata, q, hi;
	logic [15:0]        supplyCode, gainCode, refCode;
	logic signed [23:0] accumIn;
	int                 n_mismatch, check_count;
	logic signed [23:0] accs [4] = '{24'sh400000, 24'sh0, 24'sh7fffff, 24'sh800000};
	logic [31:0]        codes [4] = '{32'h7800, 32'h0, 32'h7fff, 32'h8000};
	logic [31:0]        mons [4] = '{32'h0, 32'h3c00, 32'h7800, 32'h3000};

	adcr_ctrl #(.CONV_CYCLES(16'h0008)) dut (
		.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .resetPinN(resetPinN),
		.powerDownN(powerDownN), .startPin(startPin), .clockSourceSelect(clockSourceSelect),
		.xtalClk(xtalClk), .bidirClockPinIn(bidirClockPinIn),
		.bidirClockPinOut(bidirClockPinOut), .bidirClockPinOe(bidirClockPinOe),
		.sysClkOut(sysClkOut), .dataReadyN(dataReadyN), .sclk(sclk), .csN(csN),
		.avddAboveReset(avddAboveReset), .supplyBelowTrip(supplyBelowTrip),
		.supplyAboveHyst(supplyAboveHyst), .accumIn(accumIn), .supplyCode(supplyCode),
		.gainCode(gainCode), .refCode(refCode), .filterClear(filterClear),
		.converting(converting));
	adcr_host host (.go(go), .sclk(sclk), .csN(csN), .done(done));
	assign hready = hreadyout;

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// even half periods never meet the probe instant one ns after a rising edge
	always #40 xtalClk = ~xtalClk;
	always #60 bidirClockPinIn = ~bidirClockPinIn;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	function automatic logic pick(input int k);
		return k == 0 ? converting : k == 1 ? dataReadyN : done;
	endfunction
	task automatic waitv(input int k, input logic v);
		int n;
		n = 0;
		while (pick(k) !== v) begin
			@(negedge ref_clk);
			if (++n > 300) begin
				n_mismatch++;
				tally_and_finish;
			end
		end
	endtask
	task automatic waitrdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			if (++n > 50) begin
				n_mismatch++;
				tally_and_finish;
			end
		end while (hready !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		waitrdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waitrdy;
		q = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask
	// one conversion: start is dropped once converting, so exactly one result lands
	task automatic conv;
		@(posedge ref_clk);
		startPin <= 1'b1;
		waitv(0, 1'b1);
		@(posedge ref_clk);
		startPin <= 1'b0;
		waitv(0, 1'b0);
		waitv(1, 1'b0);
		cyc(2);
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		{hsel, hwrite, startPin, clockSourceSelect, xtalClk, bidirClockPinIn, supplyBelowTrip, go} = '0;
		{resetPinN, powerDownN, avddAboveReset, supplyAboveHyst, rst} = '1;
		{haddr, htrans, hwdata, accumIn} = '0;
		hsize = 3'h2;
		supplyCode = 16'h3c00;
		gainCode = 16'h7800;
		refCode = 16'h3000;
		n_mismatch = 0;
		check_count = 0;
		cyc(4);
		rst <= 1'b0;
		cyc(3);
		rdc(8'h00, 32'h1);
		chk("oe", bidirClockPinOe, 1'b1);
		chk("resp", hresp, 1'b0);
		clockSourceSelect <= 1'b1;
		cyc(4);
		rdc(8'h04, 32'h10);
		clockSourceSelect <= 1'b0;
		#1;
		chk("oe", bidirClockPinOe, 1'b0);
		chk("mux", sysClkOut, bidirClockPinIn);
		bus(1'b1, 8'h00, 32'h0);
		cyc(3);
		#1;
		chk("oe", bidirClockPinOe, 1'b0);
		chk("mux", sysClkOut, xtalClk);
		for (int i = 0; i < 4; i++) begin
			accumIn <= accs[i];
			conv;
			rdc(8'h04, 32'h1);
			rdc(8'h08, codes[i]);
			chk("data_ready_n", dataReadyN, 1'b0);
		end
		for (int m = 1; m < 4; m++) begin
			bus(1'b1, 8'h00, m * 2 + 1);
			conv;
			rdc(8'h08, mons[m]);
		end
		supplyBelowTrip <= 1'b1;
		supplyAboveHyst <= 1'b0;
		bus(1'b1, 8'h00, 32'h3);
		conv;
		rdc(8'h08, 32'h0);
		rdc(8'h04, 32'h2);
		supplyBelowTrip <= 1'b0;
		cyc(5);
		rdc(8'h04, 32'h2);
		supplyAboveHyst <= 1'b1;
		cyc(5);
		rdc(8'h04, 32'h0);
		startPin <= 1'b1;
		waitv(1, 1'b1);
		waitv(1, 1'b0);
		hi = 0;
		repeat (12) begin
			@(negedge ref_clk);
			hi += dataReadyN;
		end
		chk("pulse", hi, 32'h1);
		startPin <= 1'b0;
		waitv(0, 1'b0);
		cyc(3);
		go <= 1'b1;
		waitv(2, 1'b1);
		go <= 1'b0;
		chk("data_ready_n", dataReadyN, 1'b1);
		rdc(8'h04, 32'h0);
		bus(1'b1, 8'h00, 32'h5);
		powerDownN <= 1'b0;
		cyc(6);
		rdc(8'h04, 32'h8);
		powerDownN <= 1'b1;
		cyc(4);
		rdc(8'h00, 32'h5);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, 8'h00, 32'h6);
			if (k == 0) resetPinN <= 1'b0;
			if (k == 1) avddAboveReset <= 1'b0;
			if (k == 2) bus(1'b1, 8'h0c, 32'h1);
			cyc(8);
			resetPinN <= 1'b1;
			avddAboveReset <= 1'b1;
			cyc(6);
			rdc(8'h00, 32'h1);
		end
		rdc(8'h10, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(3);
		rdc(8'h00, 32'h1);
		tally_and_finish;
	end
endmodule
